/* rtl/mcr_map.vh */
`ifndef MCR_MAP_VH
`define MCR_MAP_VH

// Register addresses on the 6-bit register port
`define MCR_ADDR_LINE_CYCLE 6'h13
`define MCR_ADDR_SAG_DUR 6'h14
`define MCR_ADDR_SAG_LVL 6'h15
`define MCR_ADDR_VOLTAGE_PEAK_THRESHOLD 6'h16
`define MCR_ADDR_CURRENT_PEAK_THRESHOLD 6'h17
`define MCR_ADDR_GAIN 6'h18
`define MCR_ADDR_A_WGAIN 6'h19
`define MCR_ADDR_B_WGAIN 6'h1A
`define MCR_ADDR_C_WGAIN 6'h1B
`define MCR_ADDR_A_VAGAIN 6'h1C
`define MCR_ADDR_B_VAGAIN 6'h1D
`define MCR_ADDR_C_VAGAIN 6'h1E
`define MCR_ADDR_A_PHCAL 6'h1F
`define MCR_ADDR_B_PHCAL 6'h20
`define MCR_ADDR_C_PHCAL 6'h21
`define MCR_ADDR_A_POFS 6'h22
`define MCR_ADDR_B_POFS 6'h23
`define MCR_ADDR_C_POFS 6'h24
`define MCR_ADDR_PULSE_NUM 6'h25
`define MCR_ADDR_PULSE_DEN 6'h26

// Reset values
`define MCR_RST_LINE_CYCLE 16'hFFFF
`define MCR_RST_SAG_DUR 8'hFF
`define MCR_RST_SAG_LVL 8'h00
`define MCR_RST_VOLTAGE_PEAK_THRESHOLD 8'hFF
`define MCR_RST_CURRENT_PEAK_THRESHOLD 8'hFF
`define MCR_RST_GAIN 8'h00
`define MCR_RST_GAIN12 12'h000
`define MCR_RST_PHCAL 5'h00
`define MCR_RST_PULSE_NUM 12'h000
`define MCR_RST_PULSE_DEN 12'h03F

// Constants of the internal counters
`define MCR_ZERO16 16'h0000
`define MCR_ONE16 16'h0001
`define MCR_ZERO8 8'h00
`define MCR_ONE8 8'h01
`define MCR_MAX8 8'hFF

`endif

/* rtl/mcr_sag_det.v */
`timescale 1ns/100ps
`default_nettype none
`include "mcr_map.vh"

module mcr_sag_det (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Half-cycle level from the voltage channel
  input wire half_cycle_i,
  input wire [7:0] level_i,
  // Shared settings
  input wire [7:0] threshold_i,
  input wire [7:0] duration_i,
  // Event
  output reg sag_event_o
);

  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg event_next;

  always @* begin
    count_next = count_reg;
    event_next = 1'b0;
    if (half_cycle_i) begin
      if (level_i < threshold_i) begin
        // Saturate so a long sag never wraps into a second event
        if (count_reg != `MCR_MAX8) begin
          count_next = count_reg + `MCR_ONE8;
        end
        if ((count_reg != `MCR_MAX8) && (count_next == duration_i)) begin
          event_next = 1'b1;
        end
      end else begin
        count_next = `MCR_ZERO8;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= `MCR_ZERO8;
      sag_event_o <= 1'b0;
    end else begin
      count_reg <= count_next;
      sag_event_o <= event_next;
    end
  end

endmodule

`default_nettype wire

/* rtl/mcr_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "mcr_map.vh"

module mcr_regs (
  // Clock and reset
  input wire REF_CLK_I,
  input wire RST_I,
  // Register port
  input wire [5:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [15:0] WR_DATA_I,
  output reg [15:0] RD_DATA_O,
  output reg RD_VALID_O,
  // Line window
  input wire LINE_HALF_CYCLE_I,
  output reg LINE_WINDOW_DONE_O,
  // Peak detection
  input wire VOLT_SAMPLE_VALID_I,
  input wire [7:0] VOLT_SAMPLE_I,
  input wire CURR_SAMPLE_VALID_I,
  input wire [7:0] CURR_SAMPLE_I,
  output reg VOLTAGE_PEAK_FLAG_O,
  output reg CURRENT_PEAK_FLAG_O,
  // Sag detection, one half-cycle level per phase
  input wire [2:0] SAG_HALF_CYCLE_I,
  input wire [23:0] SAG_LEVEL_I,
  output wire [2:0] SAG_EVENT_O,
  // Configuration to the datapath
  output reg [15:0] LINE_CYCLE_COUNT_O,
  output reg [7:0] SAG_DURATION_CYCLES_O,
  output reg [7:0] SAG_THRESHOLD_LEVEL_O,
  output reg [7:0] VOLTAGE_PEAK_THRESHOLD_O,
  output reg [7:0] CURRENT_PEAK_THRESHOLD_O,
  output reg [7:0] AMP_GAIN_CONFIG_O,
  output reg [11:0] PHASE_A_ACTIVE_GAIN_O,
  output reg [11:0] PHASE_B_ACTIVE_GAIN_O,
  output reg [11:0] PHASE_C_ACTIVE_GAIN_O,
  output reg [11:0] PHASE_A_APPARENT_GAIN_O,
  output reg [11:0] PHASE_B_APPARENT_GAIN_O,
  output reg [11:0] PHASE_C_APPARENT_GAIN_O,
  output reg [4:0] PHASE_A_PHASE_CAL_O,
  output reg [4:0] PHASE_B_PHASE_CAL_O,
  output reg [4:0] PHASE_C_PHASE_CAL_O,
  output reg [11:0] PHASE_A_POWER_OFFSET_O,
  output reg [11:0] PHASE_B_POWER_OFFSET_O,
  output reg [11:0] PHASE_C_POWER_OFFSET_O,
  output reg [11:0] PULSE_SCALE_NUMERATOR_O,
  output reg [11:0] PULSE_SCALE_DENOMINATOR_O
);

  reg [15:0] half_count_reg;
  reg [15:0] half_count_next;
  reg window_done_next;
  reg [15:0] rd_data_next;

  function wr_hit;
    input [5:0] addr;
    input [5:0] target;
    input wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Zero fill up to the 16-bit read word, kept explicit
  function [15:0] pad8;
    input [7:0] v;
    begin
      pad8 = `MCR_ZERO16;
      pad8[7:0] = v;
    end
  endfunction

  function [15:0] pad12;
    input [11:0] v;
    begin
      pad12 = `MCR_ZERO16;
      pad12[11:0] = v;
    end
  endfunction

  function [15:0] pad5;
    input [4:0] v;
    begin
      pad5 = `MCR_ZERO16;
      pad5[4:0] = v;
    end
  endfunction

  function [15:0] inc16;
    input [15:0] v;
    begin
      inc16 = v + `MCR_ONE16;
    end
  endfunction

  // Register writes; narrow registers take the low bits of the data
  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      LINE_CYCLE_COUNT_O <= `MCR_RST_LINE_CYCLE;
      SAG_DURATION_CYCLES_O <= `MCR_RST_SAG_DUR;
      SAG_THRESHOLD_LEVEL_O <= `MCR_RST_SAG_LVL;
      VOLTAGE_PEAK_THRESHOLD_O <= `MCR_RST_VOLTAGE_PEAK_THRESHOLD;
      CURRENT_PEAK_THRESHOLD_O <= `MCR_RST_CURRENT_PEAK_THRESHOLD;
      AMP_GAIN_CONFIG_O <= `MCR_RST_GAIN;
      PHASE_A_ACTIVE_GAIN_O <= `MCR_RST_GAIN12;
      PHASE_B_ACTIVE_GAIN_O <= `MCR_RST_GAIN12;
      PHASE_C_ACTIVE_GAIN_O <= `MCR_RST_GAIN12;
      PHASE_A_APPARENT_GAIN_O <= `MCR_RST_GAIN12;
      PHASE_B_APPARENT_GAIN_O <= `MCR_RST_GAIN12;
      PHASE_C_APPARENT_GAIN_O <= `MCR_RST_GAIN12;
      PHASE_A_PHASE_CAL_O <= `MCR_RST_PHCAL;
      PHASE_B_PHASE_CAL_O <= `MCR_RST_PHCAL;
      PHASE_C_PHASE_CAL_O <= `MCR_RST_PHCAL;
      PHASE_A_POWER_OFFSET_O <= `MCR_RST_GAIN12;
      PHASE_B_POWER_OFFSET_O <= `MCR_RST_GAIN12;
      PHASE_C_POWER_OFFSET_O <= `MCR_RST_GAIN12;
      PULSE_SCALE_NUMERATOR_O <= `MCR_RST_PULSE_NUM;
      PULSE_SCALE_DENOMINATOR_O <= `MCR_RST_PULSE_DEN;
    end else begin
      if (wr_hit(ADDR_I, `MCR_ADDR_LINE_CYCLE, WR_I)) begin
        LINE_CYCLE_COUNT_O <= WR_DATA_I;
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_SAG_DUR, WR_I)) begin
        SAG_DURATION_CYCLES_O <= WR_DATA_I[7:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_SAG_LVL, WR_I)) begin
        SAG_THRESHOLD_LEVEL_O <= WR_DATA_I[7:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_VOLTAGE_PEAK_THRESHOLD, WR_I)) begin
        VOLTAGE_PEAK_THRESHOLD_O <= WR_DATA_I[7:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_CURRENT_PEAK_THRESHOLD, WR_I)) begin
        CURRENT_PEAK_THRESHOLD_O <= WR_DATA_I[7:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_GAIN, WR_I)) begin
        AMP_GAIN_CONFIG_O <= WR_DATA_I[7:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_A_WGAIN, WR_I)) begin
        PHASE_A_ACTIVE_GAIN_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_B_WGAIN, WR_I)) begin
        PHASE_B_ACTIVE_GAIN_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_C_WGAIN, WR_I)) begin
        PHASE_C_ACTIVE_GAIN_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_A_VAGAIN, WR_I)) begin
        PHASE_A_APPARENT_GAIN_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_B_VAGAIN, WR_I)) begin
        PHASE_B_APPARENT_GAIN_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_C_VAGAIN, WR_I)) begin
        PHASE_C_APPARENT_GAIN_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_A_PHCAL, WR_I)) begin
        PHASE_A_PHASE_CAL_O <= WR_DATA_I[4:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_B_PHCAL, WR_I)) begin
        PHASE_B_PHASE_CAL_O <= WR_DATA_I[4:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_C_PHCAL, WR_I)) begin
        PHASE_C_PHASE_CAL_O <= WR_DATA_I[4:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_A_POFS, WR_I)) begin
        PHASE_A_POWER_OFFSET_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_B_POFS, WR_I)) begin
        PHASE_B_POWER_OFFSET_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_C_POFS, WR_I)) begin
        PHASE_C_POWER_OFFSET_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_PULSE_NUM, WR_I)) begin
        PULSE_SCALE_NUMERATOR_O <= WR_DATA_I[11:0];
      end
      if (wr_hit(ADDR_I, `MCR_ADDR_PULSE_DEN, WR_I)) begin
        PULSE_SCALE_DENOMINATOR_O <= WR_DATA_I[11:0];
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always @* begin
    rd_data_next = `MCR_ZERO16;
    case (ADDR_I)
      `MCR_ADDR_LINE_CYCLE: rd_data_next = LINE_CYCLE_COUNT_O;
      `MCR_ADDR_SAG_DUR: rd_data_next = pad8(SAG_DURATION_CYCLES_O);
      `MCR_ADDR_SAG_LVL: rd_data_next = pad8(SAG_THRESHOLD_LEVEL_O);
      `MCR_ADDR_VOLTAGE_PEAK_THRESHOLD: rd_data_next = pad8(VOLTAGE_PEAK_THRESHOLD_O);
      `MCR_ADDR_CURRENT_PEAK_THRESHOLD: rd_data_next = pad8(CURRENT_PEAK_THRESHOLD_O);
      `MCR_ADDR_GAIN: rd_data_next = pad8(AMP_GAIN_CONFIG_O);
      `MCR_ADDR_A_WGAIN: rd_data_next = pad12(PHASE_A_ACTIVE_GAIN_O);
      `MCR_ADDR_B_WGAIN: rd_data_next = pad12(PHASE_B_ACTIVE_GAIN_O);
      `MCR_ADDR_C_WGAIN: rd_data_next = pad12(PHASE_C_ACTIVE_GAIN_O);
      `MCR_ADDR_A_VAGAIN: rd_data_next = pad12(PHASE_A_APPARENT_GAIN_O);
      `MCR_ADDR_B_VAGAIN: rd_data_next = pad12(PHASE_B_APPARENT_GAIN_O);
      `MCR_ADDR_C_VAGAIN: rd_data_next = pad12(PHASE_C_APPARENT_GAIN_O);
      `MCR_ADDR_A_PHCAL: rd_data_next = pad5(PHASE_A_PHASE_CAL_O);
      `MCR_ADDR_B_PHCAL: rd_data_next = pad5(PHASE_B_PHASE_CAL_O);
      `MCR_ADDR_C_PHCAL: rd_data_next = pad5(PHASE_C_PHASE_CAL_O);
      `MCR_ADDR_A_POFS: rd_data_next = pad12(PHASE_A_POWER_OFFSET_O);
      `MCR_ADDR_B_POFS: rd_data_next = pad12(PHASE_B_POWER_OFFSET_O);
      `MCR_ADDR_C_POFS: rd_data_next = pad12(PHASE_C_POWER_OFFSET_O);
      `MCR_ADDR_PULSE_NUM: rd_data_next = pad12(PULSE_SCALE_NUMERATOR_O);
      `MCR_ADDR_PULSE_DEN: rd_data_next = pad12(PULSE_SCALE_DENOMINATOR_O);
      default: rd_data_next = `MCR_ZERO16;
    endcase
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      RD_DATA_O <= `MCR_ZERO16;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= RD_I;
      if (RD_I) begin
        RD_DATA_O <= rd_data_next;
      end
    end
  end

  // Line window: writing the count restarts it so no stale span completes
  always @* begin
    half_count_next = half_count_reg;
    window_done_next = 1'b0;
    if (wr_hit(ADDR_I, `MCR_ADDR_LINE_CYCLE, WR_I)) begin
      half_count_next = `MCR_ZERO16;
    end else if (LINE_HALF_CYCLE_I) begin
      if (inc16(half_count_reg) >= LINE_CYCLE_COUNT_O) begin
        half_count_next = `MCR_ZERO16;
        window_done_next = 1'b1;
      end else begin
        half_count_next = inc16(half_count_reg);
      end
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      half_count_reg <= `MCR_ZERO16;
      LINE_WINDOW_DONE_O <= 1'b0;
      VOLTAGE_PEAK_FLAG_O <= 1'b0;
      CURRENT_PEAK_FLAG_O <= 1'b0;
    end else begin
      half_count_reg <= half_count_next;
      LINE_WINDOW_DONE_O <= window_done_next;
      // Strictly above; a threshold of FF can never trip
      VOLTAGE_PEAK_FLAG_O <= VOLT_SAMPLE_VALID_I &&
        (VOLT_SAMPLE_I > VOLTAGE_PEAK_THRESHOLD_O);
      CURRENT_PEAK_FLAG_O <= CURR_SAMPLE_VALID_I &&
        (CURR_SAMPLE_I > CURRENT_PEAK_THRESHOLD_O);
    end
  end

  // One detector per phase, all sharing the same duration and level
  mcr_sag_det u_sag_a (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .half_cycle_i(SAG_HALF_CYCLE_I[0]),
    .level_i(SAG_LEVEL_I[7:0]),
    .threshold_i(SAG_THRESHOLD_LEVEL_O),
    .duration_i(SAG_DURATION_CYCLES_O),
    .sag_event_o(SAG_EVENT_O[0])
  );

  mcr_sag_det u_sag_b (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .half_cycle_i(SAG_HALF_CYCLE_I[1]),
    .level_i(SAG_LEVEL_I[15:8]),
    .threshold_i(SAG_THRESHOLD_LEVEL_O),
    .duration_i(SAG_DURATION_CYCLES_O),
    .sag_event_o(SAG_EVENT_O[1])
  );

  mcr_sag_det u_sag_c (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .half_cycle_i(SAG_HALF_CYCLE_I[2]),
    .level_i(SAG_LEVEL_I[23:16]),
    .threshold_i(SAG_THRESHOLD_LEVEL_O),
    .duration_i(SAG_DURATION_CYCLES_O),
    .sag_event_o(SAG_EVENT_O[2])
  );

endmodule

`default_nettype wire

/* bench/mcr_regs_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_chk (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic [5:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] WR_DATA_I,
  input wire logic RD_VALID_O,
  // Datapath side
  input wire logic LINE_HALF_CYCLE_I,
  input wire logic LINE_WINDOW_DONE_O,
  input wire logic VOLT_SAMPLE_VALID_I,
  input wire logic [7:0] VOLT_SAMPLE_I,
  input wire logic CURR_SAMPLE_VALID_I,
  input wire logic [7:0] CURR_SAMPLE_I,
  input wire logic VOLTAGE_PEAK_FLAG_O,
  input wire logic CURRENT_PEAK_FLAG_O,
  input wire logic [2:0] SAG_HALF_CYCLE_I,
  input wire logic [23:0] SAG_LEVEL_I,
  input wire logic [2:0] SAG_EVENT_O,
  // Configuration
  input wire logic [15:0] LINE_CYCLE_COUNT_O,
  input wire logic [7:0] SAG_DURATION_CYCLES_O,
  input wire logic [7:0] SAG_THRESHOLD_LEVEL_O,
  input wire logic [7:0] VOLTAGE_PEAK_THRESHOLD_O,
  input wire logic [7:0] CURRENT_PEAK_THRESHOLD_O,
  input wire logic [4:0] PHASE_A_PHASE_CAL_O,
  input wire logic [11:0] PULSE_SCALE_NUMERATOR_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  rd_valid_pulse_a: assert property (
    RD_VALID_O == $past(RD_I)) else $error("read valid misplaced");
  line_write_a: assert property (
    WR_I && ADDR_I == 6'h13 |=> LINE_CYCLE_COUNT_O == $past(WR_DATA_I))
    else $error("line count not written");
  window_cause_a: assert property (
    LINE_WINDOW_DONE_O |-> $past(LINE_HALF_CYCLE_I))
    else $error("window done without strobe");
  sag_dur_write_a: assert property (
    WR_I && ADDR_I == 6'h14 |=> SAG_DURATION_CYCLES_O == $past(WR_DATA_I[7:0]))
    else $error("sag duration not written");
  sag_dur_hold_a: assert property (
    !$stable(SAG_DURATION_CYCLES_O) |-> $past(WR_I) && $past(ADDR_I) == 6'h14)
    else $error("sag duration changed unasked");
  sag_lvl_write_a: assert property (
    WR_I && ADDR_I == 6'h15 |=> SAG_THRESHOLD_LEVEL_O == $past(WR_DATA_I[7:0]))
    else $error("sag level not written");
  volt_peak_a: assert property (
    VOLTAGE_PEAK_FLAG_O == $past(VOLT_SAMPLE_VALID_I &&
      VOLT_SAMPLE_I > VOLTAGE_PEAK_THRESHOLD_O)) else $error("volt peak wrong");
  curr_peak_a: assert property (
    CURRENT_PEAK_FLAG_O == $past(CURR_SAMPLE_VALID_I &&
      CURR_SAMPLE_I > CURRENT_PEAK_THRESHOLD_O)) else $error("curr peak wrong");
  phase_cal_a: assert property (
    WR_I && ADDR_I == 6'h1F |=> PHASE_A_PHASE_CAL_O == $past(WR_DATA_I[4:0]))
    else $error("phase cal not written");
  pulse_num_a: assert property (
    WR_I && ADDR_I == 6'h25 |=> PULSE_SCALE_NUMERATOR_O == $past(WR_DATA_I[11:0]))
    else $error("numerator not written");
  sag_cause_a: assert property (
    SAG_EVENT_O[0] |-> $past(SAG_HALF_CYCLE_I[0]) &&
      $past(SAG_LEVEL_I[7:0]) < $past(SAG_THRESHOLD_LEVEL_O))
    else $error("sag event without low half cycle");
  rd_c: cover property (RD_I ##1 RD_VALID_O);
  peak_c: cover property (VOLTAGE_PEAK_FLAG_O);
  sag_c: cover property (SAG_EVENT_O[0]);
endmodule
bind mcr_regs mcr_regs_chk mcr_regs_chk_inst (.*);
`default_nettype wire

/* bench/mcr_host.sv */
`timescale 1ns/100ps
`default_nettype none
module mcr_host (
  // Clock and read return
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i,
  // Register port drive
  output var logic [5:0] addr_o,
  output var logic wr_o,
  output var logic rd_o,
  output var logic [15:0] wr_data_o
);
  initial begin
    addr_o = 6'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wr_data_o = 16'h0000;
  end
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    wr_data_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // Stale data must not look valid to the device
    wr_data_o = ~d;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [15:0] d,
                        output bit ok);
    int n;
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    n = 0;
    while (rd_valid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    ok = (rd_valid_i === 1'b1);
    d = rd_data_i;
  endtask
endmodule
`default_nettype wire

/* bench/mcr_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module mcr_regs_test;
  logic clk = 1'b0, rst = 1'b1, half = 1'b0, vv = 1'b0, cv = 1'b0;
  logic [7:0] vs = 8'h00, cs = 8'h00;
  logic [2:0] sag_hc = 3'h0;
  logic [23:0] sag_lv = 24'h000000;
  wire logic [5:0] addr;
  wire logic wr, rd, rvalid, done, vflag, iflag;
  wire logic [15:0] wdata, rdata, line_cnt;
  wire logic [2:0] sag_ev;
  wire logic [7:0] sag_dur, sag_lvl, vpk, ipk, amp_cfg;
  wire logic [4:0] cal_a, cal_b, cal_c;
  wire logic [11:0] act_a, act_b, act_c, app_a, app_b, app_c;
  wire logic [11:0] ofs_a, ofs_b, ofs_c, num, den;
  int err_count = 0, check_count = 0;
  always #20 clk = ~clk;
  mcr_host mcr_host_inst (.clk_i(clk), .rd_data_i(rdata), .rd_valid_i(rvalid),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wr_data_o(wdata));
  mcr_regs mcr_regs_inst (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WR_I(wr), .RD_I(rd), .WR_DATA_I(wdata), .RD_DATA_O(rdata),
    .RD_VALID_O(rvalid), .LINE_HALF_CYCLE_I(half), .LINE_WINDOW_DONE_O(done),
    .VOLT_SAMPLE_VALID_I(vv), .VOLT_SAMPLE_I(vs), .CURR_SAMPLE_VALID_I(cv),
    .CURR_SAMPLE_I(cs), .VOLTAGE_PEAK_FLAG_O(vflag),
    .CURRENT_PEAK_FLAG_O(iflag), .SAG_HALF_CYCLE_I(sag_hc),
    .SAG_LEVEL_I(sag_lv), .SAG_EVENT_O(sag_ev), .LINE_CYCLE_COUNT_O(line_cnt),
    .SAG_DURATION_CYCLES_O(sag_dur), .SAG_THRESHOLD_LEVEL_O(sag_lvl),
    .VOLTAGE_PEAK_THRESHOLD_O(vpk), .CURRENT_PEAK_THRESHOLD_O(ipk),
    .AMP_GAIN_CONFIG_O(amp_cfg), .PHASE_A_ACTIVE_GAIN_O(act_a),
    .PHASE_B_ACTIVE_GAIN_O(act_b), .PHASE_C_ACTIVE_GAIN_O(act_c),
    .PHASE_A_APPARENT_GAIN_O(app_a), .PHASE_B_APPARENT_GAIN_O(app_b),
    .PHASE_C_APPARENT_GAIN_O(app_c), .PHASE_A_PHASE_CAL_O(cal_a),
    .PHASE_B_PHASE_CAL_O(cal_b), .PHASE_C_PHASE_CAL_O(cal_c),
    .PHASE_A_POWER_OFFSET_O(ofs_a), .PHASE_B_POWER_OFFSET_O(ofs_b),
    .PHASE_C_POWER_OFFSET_O(ofs_c), .PULSE_SCALE_NUMERATOR_O(num),
    .PULSE_SCALE_DENOMINATOR_O(den));
  function automatic logic [15:0] rst_val(input logic [5:0] a);
    case (a)
      6'h13: rst_val = 16'hFFFF;
      6'h14, 6'h16, 6'h17: rst_val = 16'h00FF;
      6'h26: rst_val = 16'h003F;
      default: rst_val = 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] mask(input logic [5:0] a);
    case (a)
      6'h13: mask = 16'hFFFF;
      6'h14, 6'h15, 6'h16, 6'h17, 6'h18: mask = 16'h00FF;
      6'h1F, 6'h20, 6'h21: mask = 16'h001F;
      6'h12, 6'h27: mask = 16'h0000;
      default: mask = 16'h0FFF;
    endcase
  endfunction
  function automatic logic [15:0] wv(input logic [5:0] a);
    wv = (16'hA5C3 ^ {10'h000, a}) & mask(a);
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    mcr_host_inst.rd_reg(a, d, ok);
    if (!ok) begin
      err_count++;
      $display("wrong value read_valid expected 1 seen 0");
      finish_test();
    end else begin
      chk($sformatf("reg_%h", a), e, d);
    end
  endtask
  initial begin
    logic [5:0] a;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 18; i <= 39; i++) begin
      a = i[5:0];
      rd_chk(a, rst_val(a));
    end
    for (int i = 18; i <= 39; i++) begin
      a = i[5:0];
      mcr_host_inst.wr_reg(a, 16'hA5C3 ^ {10'h000, a});
      rd_chk(a, wv(a));
    end
    chk("line_count", 16'hA5D0, line_cnt);
    chk("sag_dur", wv(6'h14), {8'h00, sag_dur});
    chk("sag_lvl", wv(6'h15), {8'h00, sag_lvl});
    chk("volt_thr", wv(6'h16), {8'h00, vpk});
    chk("curr_thr", wv(6'h17), {8'h00, ipk});
    chk("amp_cfg", wv(6'h18), {8'h00, amp_cfg});
    chk("act_a", wv(6'h19), {4'h0, act_a});
    chk("act_b", wv(6'h1A), {4'h0, act_b});
    chk("act_c", wv(6'h1B), {4'h0, act_c});
    chk("app_a", wv(6'h1C), {4'h0, app_a});
    chk("app_b", wv(6'h1D), {4'h0, app_b});
    chk("app_c", wv(6'h1E), {4'h0, app_c});
    chk("cal_a", wv(6'h1F), {11'h000, cal_a});
    chk("cal_b", wv(6'h20), {11'h000, cal_b});
    chk("cal_c", wv(6'h21), {11'h000, cal_c});
    chk("ofs_a", wv(6'h22), {4'h0, ofs_a});
    chk("ofs_b", wv(6'h23), {4'h0, ofs_b});
    chk("ofs_c", wv(6'h24), {4'h0, ofs_c});
    chk("num", wv(6'h25), {4'h0, num});
    chk("den", wv(6'h26), {4'h0, den});
    mcr_host_inst.wr_reg(6'h16, 16'h007F);
    mcr_host_inst.wr_reg(6'h17, 16'h007F);
    @(negedge clk);
    vv = 1'b1;
    vs = 8'h80;
    cv = 1'b1;
    cs = 8'h7F;
    @(negedge clk);
    vs = 8'h7F;
    cs = 8'h80;
    chk("volt_peak", 16'h0001, {15'h0000, vflag});
    chk("curr_peak", 16'h0000, {15'h0000, iflag});
    @(negedge clk);
    vv = 1'b0;
    cv = 1'b0;
    chk("volt_equal", 16'h0000, {15'h0000, vflag});
    chk("curr_above", 16'h0001, {15'h0000, iflag});
    mcr_host_inst.wr_reg(6'h14, 16'h0002);
    mcr_host_inst.wr_reg(6'h15, 16'h0040);
    @(negedge clk);
    sag_lv = 24'h00403F;
    sag_hc = 3'h3;
    repeat (2) @(negedge clk);
    sag_hc = 3'h0;
    chk("sag_event", 16'h0001, {13'h0000, sag_ev});
    @(negedge clk);
    sag_hc = 3'h1;
    @(negedge clk);
    sag_hc = 3'h0;
    chk("sag_once", 16'h0000, {13'h0000, sag_ev});
    mcr_host_inst.wr_reg(6'h13, 16'h0003);
    @(negedge clk);
    half = 1'b1;
    repeat (2) @(negedge clk);
    chk("window_early", 16'h0000, {15'h0000, done});
    @(negedge clk);
    half = 1'b0;
    chk("window_done", 16'h0001, {15'h0000, done});
    finish_test();
  end
endmodule
`default_nettype wire
